// ### common/lpms_consts.svh
// Constants for the low-power mode sequencer: timing counts and field codes.
// Assumes a 100 MHz system clock; included by the package and the design files.
`ifndef LPMS_CONSTS_SVH
`define LPMS_CONSTS_SVH
`define LPMS_CLK_HZ 100000000
`define LPMS_STARTUP_S 300
`define LPMS_DEEP_SEND_MIN_S 60
`define LPMS_MODE_NONE 2'h0
`define LPMS_MODE_SLEEP 2'h1
`define LPMS_MODE_DEEP 2'h2
`define LPMS_PRIO_LOW 2'h0
`define LPMS_PRIO_HIGH 2'h1
`define LPMS_PRIO_PANIC 2'h2
`define LPMS_IRQ_BITS 4
`define LPMS_IRQ_SLEEP_ENTRY 0
`define LPMS_IRQ_DEEP_ENTRY 1
`define LPMS_IRQ_WAKE 2
`define LPMS_IRQ_STARTUP_DONE 3
`define LPMS_ADDR_STATUS 4'h0
`define LPMS_ADDR_MASK 4'h1
`define LPMS_ADDR_STATE 4'h2
`define LPMS_ADDR_CTRL 4'h3
`define LPMS_DS_IO_MASK 16'h3FFF
`endif

// ### common/lpms_pkg.sv
// Types shared by the low-power mode sequencer design files.
// Assumes lpms_consts.svh is on the include path.
`include "lpms_consts.svh"
package lpms_pkg;
  typedef enum logic [2:0] {
    LPMS_NORMAL = 3'b001,
    LPMS_SLEEP = 3'b010,
    LPMS_DEEP = 3'b100
  } lpms_state_t;
  typedef logic [1:0] lpms_mode_t;
  typedef logic [1:0] lpms_prio_t;
endpackage

// ### logic/lpms_seq.sv
// Low-power mode sequencer: decides sleep and deep sleep, gates receiver and modem power,
// and steers record saving and sending. Assumes synchronous inputs on one 100 MHz clock.
// Behaviour
// - Enter sleep only when mode, start-up timeout, stillness, ignition off, no USB all hold.
// - Start-up timeout of five minutes after each restart blocks both low-power states.
// - In sleep the positioning receiver sleeps while the modem stays powered.
// - Leave sleep on movement, ignition high, USB attach, or high/panic record.
// - In sleep no periodic or event record is saved.
// - Enter deep sleep on all sleep conditions plus send period above 60 seconds.
// - In deep sleep modem is off, powered only while pending data is sent.
// - In deep sleep an incoming text message never wakes the device.
// - Leave deep sleep on movement, ignition high, USB attach, or high/panic record.
// - In deep sleep records are saved, tagged with the last valid fix before entry.
// - Deep sleep records carry only the reduced I/O element set.
// - The deep sleep element always carries low priority.
// - Low records queue, high send at once, panic send at once plus text.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "lpms_consts.svh"
module lpms_seq #(
  parameter int unsigned CLK_HZ = `LPMS_CLK_HZ,
  parameter int unsigned STARTUP_S = `LPMS_STARTUP_S,
  parameter int unsigned FIX_W = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ignition_input,
  input wire logic movement,
  input wire logic usb_present,
  input wire logic [15:0] send_period_s,
  input wire logic rec_valid,
  input wire lpms_pkg::lpms_prio_t rec_prio,
  input wire logic rec_periodic,
  input wire logic [15:0] rec_io,
  input wire logic sms_in,
  input wire logic fix_valid,
  input wire logic [FIX_W-1:0] fix,
  input wire logic data_pending,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output logic gnss_sleep,
  output logic modem_on,
  output logic save_en,
  output logic rec_save,
  output logic [15:0] rec_save_io,
  output logic [FIX_W-1:0] rec_save_fix,
  output logic rec_save_prio_high,
  output logic rec_queue,
  output logic rec_send_now,
  output logic rec_send_sms,
  output logic sms_wake,
  output logic deep_flag,
  output lpms_pkg::lpms_prio_t deep_flag_prio
);
  import lpms_pkg::*;

  typedef struct packed {
    lpms_state_t state;
    lpms_mode_t mode;
    logic [15:0] secs;
    logic startup_done;
    logic [FIX_W-1:0] last_fix;
    logic [FIX_W-1:0] held_fix;
    logic [`LPMS_IRQ_BITS-1:0] status;
    logic [`LPMS_IRQ_BITS-1:0] mask;
    logic [31:0] rdata;
    logic rec_save;
    logic [15:0] rec_io;
    logic [FIX_W-1:0] rec_fix;
    logic rec_high;
    logic rec_queue;
    logic rec_send;
    logic rec_sms;
    logic sms_wake;
  } lpms_st_t;

  lpms_st_t st;
  lpms_st_t next_st;
  logic tick;
  logic still_off;
  logic urgent;
  logic wake;
  logic sleep_ok;
  logic deep_ok;
  logic can_save;
  logic [`LPMS_IRQ_BITS-1:0] ev;

  // Seconds are counted with a divider pulse so the five minute count stays small.
  lpms_tick #(
    .DIV(CLK_HZ)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Ignition level is read directly as on/off.
  assign still_off = !movement && !ignition_input && !usb_present;
  assign urgent = rec_valid && (rec_prio == `LPMS_PRIO_HIGH || rec_prio == `LPMS_PRIO_PANIC);
  // Text messages are not part of the wake set, so deep sleep ignores them.
  assign wake = movement || ignition_input || usb_present || urgent;
  assign sleep_ok = st.mode == `LPMS_MODE_SLEEP && st.startup_done && still_off;
  assign deep_ok = st.mode == `LPMS_MODE_DEEP && st.startup_done && still_off
    && send_period_s > 16'(`LPMS_DEEP_SEND_MIN_S);
  assign can_save = st.state != LPMS_SLEEP;

  always_comb begin
    next_st = st;
    ev = '0;
    next_st.rec_save = 1'b0;
    next_st.rec_queue = 1'b0;
    next_st.rec_send = 1'b0;
    next_st.rec_sms = 1'b0;
    next_st.sms_wake = 1'b0;
    next_st.rdata = 32'h0;
    if (tick && !st.startup_done) begin
      if (st.secs >= 16'(STARTUP_S - 1)) begin
        next_st.startup_done = 1'b1;
        ev[`LPMS_IRQ_STARTUP_DONE] = 1'b1;
      end else begin
        next_st.secs = st.secs + 16'h1;
      end
    end
    if (fix_valid) begin
      next_st.last_fix = fix;
    end
    case (st.state)
      LPMS_NORMAL: begin
        if (sleep_ok) begin
          next_st.state = LPMS_SLEEP;
          ev[`LPMS_IRQ_SLEEP_ENTRY] = 1'b1;
        end else if (deep_ok) begin
          next_st.state = LPMS_DEEP;
          next_st.held_fix = st.last_fix;
          ev[`LPMS_IRQ_DEEP_ENTRY] = 1'b1;
        end
      end
      LPMS_SLEEP, LPMS_DEEP: begin
        if (wake) begin
          next_st.state = LPMS_NORMAL;
          ev[`LPMS_IRQ_WAKE] = 1'b1;
        end
      end
      default: begin
        next_st.state = LPMS_NORMAL;
      end
    endcase
    if (rec_valid && can_save) begin
      next_st.rec_save = 1'b1;
      next_st.rec_high = rec_prio != `LPMS_PRIO_LOW;
      if (st.state == LPMS_DEEP) begin
        next_st.rec_io = rec_io & `LPMS_DS_IO_MASK;
        next_st.rec_fix = st.held_fix;
      end else begin
        next_st.rec_io = rec_io;
        next_st.rec_fix = st.last_fix;
      end
      next_st.rec_queue = rec_prio == `LPMS_PRIO_LOW;
      next_st.rec_send = rec_prio != `LPMS_PRIO_LOW;
      next_st.rec_sms = rec_prio == `LPMS_PRIO_PANIC;
    end else if (rec_valid && urgent) begin
      next_st.rec_send = 1'b1;
      next_st.rec_sms = rec_prio == `LPMS_PRIO_PANIC;
    end
    next_st.sms_wake = sms_in && st.state == LPMS_NORMAL;
    if (reg_wr) begin
      if (reg_addr == `LPMS_ADDR_STATUS) begin
        next_st.status = st.status & ~reg_wdata[`LPMS_IRQ_BITS-1:0];
      end else if (reg_addr == `LPMS_ADDR_MASK) begin
        next_st.mask = reg_wdata[`LPMS_IRQ_BITS-1:0];
      end else if (reg_addr == `LPMS_ADDR_CTRL) begin
        next_st.mode = reg_wdata[1:0];
      end
    end
    // Setting wins over a clear in the same cycle so no event is lost.
    next_st.status = next_st.status | ev;
    if (reg_rd) begin
      if (reg_addr == `LPMS_ADDR_STATUS) begin
        next_st.rdata = {{(32-`LPMS_IRQ_BITS){1'b0}}, st.status};
      end else if (reg_addr == `LPMS_ADDR_MASK) begin
        next_st.rdata = {{(32-`LPMS_IRQ_BITS){1'b0}}, st.mask};
      end else if (reg_addr == `LPMS_ADDR_STATE) begin
        next_st.rdata = {27'h0, st.startup_done, 1'b0, st.state};
      end else if (reg_addr == `LPMS_ADDR_CTRL) begin
        next_st.rdata = {30'h0, st.mode};
      end else begin
        next_st.rdata = 32'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.state <= LPMS_NORMAL;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign irq = |(st.status & st.mask);
  assign gnss_sleep = st.state != LPMS_NORMAL;
  assign modem_on = st.state != LPMS_DEEP || data_pending;
  assign save_en = can_save;
  assign rec_save = st.rec_save;
  assign rec_save_io = st.rec_io;
  assign rec_save_fix = st.rec_fix;
  assign rec_save_prio_high = st.rec_high;
  assign rec_queue = st.rec_queue;
  assign rec_send_now = st.rec_send;
  assign rec_send_sms = st.rec_sms;
  assign sms_wake = st.sms_wake;
  assign deep_flag = st.state == LPMS_DEEP;
  // The deep sleep element never inherits a configured priority.
  assign deep_flag_prio = `LPMS_PRIO_LOW;

  AST_NO_EARLY_LOWPOWER: assert property (@(posedge clk) disable iff (!rst_n)
    !st.startup_done |=> st.state == LPMS_NORMAL || $past(st.state) != LPMS_NORMAL)
    else $error("Low-power state entered before start-up timeout.");
  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    $past(st.state) == LPMS_NORMAL && st.state == LPMS_SLEEP |-> $past(sleep_ok))
    else $error("Sleep entered without all conditions.");
  AST_DEEP_ENTRY: assert property (@(posedge clk) disable iff (!rst_n)
    st.state == LPMS_NORMAL && deep_ok && !sleep_ok |=> st.state == LPMS_DEEP)
    else $error("Deep sleep not entered.");
  AST_WAKE_EXIT: assert property (@(posedge clk) disable iff (!rst_n)
    st.state != LPMS_NORMAL && wake |=> st.state == LPMS_NORMAL)
    else $error("Low-power state not left on wake.");
  AST_DEEP_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    st.state == LPMS_DEEP && ignition_input |=> !deep_flag)
    else $error("Deep sleep not left on ignition.");
  AST_SLEEP_POWER: assert property (@(posedge clk) disable iff (!rst_n)
    st.state == LPMS_SLEEP |-> gnss_sleep && modem_on)
    else $error("Sleep power gating wrong.");
  AST_DEEP_MODEM: assert property (@(posedge clk) disable iff (!rst_n)
    st.state == LPMS_DEEP && !data_pending |-> !modem_on && gnss_sleep)
    else $error("Modem powered in deep sleep without data.");
  AST_SLEEP_NOSAVE: assert property (@(posedge clk) disable iff (!rst_n)
    st.state == LPMS_SLEEP |=> !rec_save)
    else $error("Record saved in sleep.");
  AST_DEEP_IO: assert property (@(posedge clk) disable iff (!rst_n)
    st.state == LPMS_DEEP && rec_valid |=> rec_save && (rec_save_io & ~`LPMS_DS_IO_MASK) == 16'h0)
    else $error("Deep sleep record not reduced.");
  AST_PANIC_SMS: assert property (@(posedge clk) disable iff (!rst_n)
    rec_valid && rec_prio == `LPMS_PRIO_PANIC |=> rec_send_now && rec_send_sms)
    else $error("Panic record not sent with text.");
  AST_NO_SMS_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    st.state == LPMS_DEEP |=> !sms_wake)
    else $error("Text message woke deep sleep.");
  AST_HIGH_SEND: assert property (@(posedge clk) disable iff (!rst_n)
    rec_valid && rec_prio == `LPMS_PRIO_HIGH |=> rec_send_now && !rec_send_sms && !rec_queue)
    else $error("High record not sent at once.");
  AST_LOW_QUEUE: assert property (@(posedge clk) disable iff (!rst_n)
    rec_valid && can_save && rec_prio == `LPMS_PRIO_LOW |=> rec_queue && !rec_send_now)
    else $error("Low record not queued.");
  AST_DEEP_FIX: assert property (@(posedge clk) disable iff (!rst_n)
    st.state == LPMS_DEEP && rec_valid |=> rec_save_fix == $past(st.held_fix))
    else $error("Deep sleep record not tagged with held fix.");
  AST_ONE_STATE: assert property (@(posedge clk) disable iff (!rst_n)
    $onehot(st.state))
    else $error("More than one operating state active.");
endmodule // lpms_seq

// ### logic/lpms_tick.sv
// Divider that produces a one-cycle pulse once per second.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "lpms_consts.svh"
module lpms_tick #(
  parameter int unsigned DIV = `LPMS_CLK_HZ
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } lpms_tick_st_t;
  lpms_tick_st_t st;
  lpms_tick_st_t next_st;
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt >= DIV - 1) begin
      next_st.cnt = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tick = st.tick;
endmodule // lpms_tick

// ### sim/low_power_mode_sequencer_tb.sv
// Self-checking bench for the low-power mode sequencer with a shortened seconds divider.
// Assumes lpms_consts.svh on the include path and the far-side model lpms_far.
`timescale 1ns/1ps
`include "lpms_consts.svh"
module low_power_mode_sequencer_tb;
  import lpms_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, send_req = 1'b0, rec_valid = 1'b0, sms_in = 1'b0;
  logic fix_valid = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ign, mov, usb, pend;
  logic [2:0] wake = 3'h0;
  logic [15:0] send_period_s = 16'h003C, rec_io = 16'hFFFF;
  lpms_prio_t rec_prio = `LPMS_PRIO_LOW;
  logic [31:0] fix = 32'hA5A50001, reg_wdata = 32'h0, reg_rdata, d;
  logic [3:0] reg_addr = 4'h0, r;
  logic irq, gnss_sleep, modem_on, save_en, rec_save, rec_queue, rec_send_now, rec_send_sms;
  logic sms_wake, deep_flag, prio_high, w;
  logic [15:0] save_io;
  logic [31:0] save_fix;
  lpms_prio_t deep_prio;
  int err_total = 0, compares = 0, cycles = 0;
  lpms_far u_far (.clk(clk), .wake_cmd(wake), .send_req(send_req), .modem_on(modem_on),
    .ignition_input(ign), .movement(mov), .usb_present(usb), .data_pending(pend));
  lpms_seq #(.CLK_HZ(10), .STARTUP_S(3), .FIX_W(32)) u_dut (.clk(clk), .rst_n(rst_n),
    .ignition_input(ign), .movement(mov), .usb_present(usb), .send_period_s(send_period_s),
    .rec_valid(rec_valid), .rec_prio(rec_prio), .rec_periodic(1'b0), .rec_io(rec_io),
    .sms_in(sms_in), .fix_valid(fix_valid), .fix(fix), .data_pending(pend),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .gnss_sleep(gnss_sleep), .modem_on(modem_on),
    .save_en(save_en), .rec_save(rec_save), .rec_save_io(save_io), .rec_save_fix(save_fix),
    .rec_save_prio_high(prio_high), .rec_queue(rec_queue), .rec_send_now(rec_send_now),
    .rec_send_sms(rec_send_sms), .sms_wake(sms_wake), .deep_flag(deep_flag),
    .deep_flag_prio(deep_prio));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rec(input lpms_prio_t p);
    @(posedge clk);
    rec_valid <= 1'b1;
    rec_prio <= p;
    @(posedge clk);
    rec_valid <= 1'b0;
    #1 r = {rec_save, rec_queue, rec_send_now, rec_send_sms};
  endtask
  // A pulse wake re-enters at once since the entry conditions still hold, so watch briefly.
  task automatic watch();
    w = 1'b0;
    repeat (3) begin
      @(posedge clk);
      #1 w = w | ~gnss_sleep;
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_sleep();
    wr(`LPMS_ADDR_CTRL, {30'h0, `LPMS_MODE_SLEEP});
    rd(`LPMS_ADDR_STATE);
    chk("state_early", d, 32'h1);
    chk("irq_rst", irq, 1'b0);
    for (int i = 0; i < 100 && d !== 32'h12; i++) begin
      rd(`LPMS_ADDR_STATE);
    end
    chk("state_sleep", d, 32'h12);
    chk("gnss", gnss_sleep, 1'b1);
    chk("modem", modem_on, 1'b1);
    chk("save_en", save_en, 1'b0);
    rec(`LPMS_PRIO_LOW);
    chk("save_sleep", r[3], 1'b0);
    fork
      rec(`LPMS_PRIO_HIGH);
      watch();
    join
    chk("send_now", r[1], 1'b1);
    chk("rec_wake", w, 1'b1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      wake <= 3'h1 << i;
      repeat (3) @(posedge clk);
      #1 chk("wake_src", {gnss_sleep, modem_on, save_en}, 3'h3);
      @(posedge clk);
      wake <= 3'h0;
      repeat (3) @(posedge clk);
      #1 chk("reenter", gnss_sleep, 1'b1);
    end
  endtask
  task automatic t_deep();
    @(posedge clk);
    wake <= 3'h1;
    wr(`LPMS_ADDR_CTRL, {30'h0, `LPMS_MODE_DEEP});
    wake <= 3'h0;
    repeat (4) @(posedge clk);
    #1 chk("deep_60", deep_flag, 1'b0);
    send_period_s <= 16'h003D;
    repeat (3) @(posedge clk);
    fix <= 32'h0000BEEF;
    rd(`LPMS_ADDR_STATE);
    chk("state_deep", d, 32'h14);
    chk("deep_out", {deep_flag, deep_prio, gnss_sleep, modem_on}, 5'h12);
    rec(`LPMS_PRIO_LOW);
    chk("deep_rec", {r, prio_high}, 5'h18);
    chk("deep_io", save_io, `LPMS_DS_IO_MASK);
    chk("deep_fix", save_fix, 32'hA5A50001);
    @(posedge clk);
    sms_in <= 1'b1;
    send_req <= 1'b1;
    @(posedge clk);
    sms_in <= 1'b0;
    send_req <= 1'b0;
    #1 chk("sms_deep", {sms_wake, deep_flag}, 2'h1);
    @(posedge clk);
    #1 chk("modem_tx", modem_on, 1'b1);
    repeat (8) @(posedge clk);
    #1 chk("modem_off", modem_on, 1'b0);
    fork
      rec(`LPMS_PRIO_PANIC);
      watch();
    join
    chk("panic", {r, prio_high}, 5'h17);
    chk("deep_wake", w, 1'b1);
  endtask
  task automatic t_irq();
    @(posedge clk);
    wake <= 3'h4;
    // The exit from deep sleep must land before the text arrives, or it is ignored.
    repeat (2) @(posedge clk);
    sms_in <= 1'b1;
    @(posedge clk);
    sms_in <= 1'b0;
    #1 chk("sms_norm", sms_wake, 1'b1);
    rd(`LPMS_ADDR_STATUS);
    chk("status", d, 32'hF);
    wr(`LPMS_ADDR_MASK, 32'h2);
    wr(4'hF, 32'hFFFFFFFF);
    rd(4'hF);
    chk("unmapped", d, 32'h0);
    chk("irq_on", irq, 1'b1);
    wr(`LPMS_ADDR_STATUS, 32'h2);
    rd(`LPMS_ADDR_STATUS);
    chk("w1c", {d, irq}, 33'h1A);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_sleep();
    t_deep();
    t_irq();
    end_of_test();
  end
endmodule // low_power_mode_sequencer_tb

// ### sim/lpms_far.sv
// Far-side model: ignition line, accelerometer, USB host and the modem's data queue.
// Assumes the bench drives the command inputs by non-blocking assignment at the clock edge.
`timescale 1ns/1ps
module lpms_far (
  input wire logic clk,
  input wire logic [2:0] wake_cmd,
  input wire logic send_req,
  input wire logic modem_on,
  output logic ignition_input,
  output logic movement,
  output logic usb_present,
  output logic data_pending
);
  logic [2:0] sent = 3'h0;
  assign ignition_input = wake_cmd[0];
  assign movement = wake_cmd[1];
  assign usb_present = wake_cmd[2];
  initial data_pending = 1'b0;
  // Queued data only drains while the modem has power, so a dead modem holds it forever.
  always @(posedge clk) begin
    if (send_req) begin
      data_pending <= 1'b1;
      sent <= 3'h0;
    end else if (data_pending && modem_on) begin
      sent <= sent + 3'h1;
      if (sent == 3'h3) begin
        data_pending <= 1'b0;
      end
    end
  end
endmodule // lpms_far
